// [inc/program_flow_pkg.sv]
// Purpose: Shared constants and types for the program flow sequencer
// Assumes: 50 MHz system clock, 32-bit word-aligned register bus
// Notes:   Register offsets are byte addresses

package program_flow_pkg;

  // Timing
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned TICK_MS     = 10;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;

  // Return stack
  localparam int unsigned STACK_DEPTH = 8;

  // Opcodes
  localparam logic [7:0] OPC_COND_BRANCH = 8'h15;
  localparam logic [7:0] OPC_BRANCH      = 8'h16;
  localparam logic [7:0] OPC_CALL        = 8'h17;
  localparam logic [7:0] OPC_RETURN      = 8'h18;
  localparam logic [7:0] OPC_WAIT        = 8'h1b;
  localparam logic [7:0] OPC_CLEAR_ERROR = 8'h24;

  // Conditional branch type that tests the timeout flag
  localparam logic [7:0] COND_TIMEOUT = 8'h08;

  // Wait types
  localparam logic [7:0] WAIT_TICKS  = 8'h00;
  localparam logic [7:0] WAIT_TARGET = 8'h01;
  localparam logic [7:0] WAIT_HOME   = 8'h02;
  localparam logic [7:0] WAIT_END    = 8'h03;
  localparam logic [7:0] WAIT_HOMING = 8'h04;

  // Value field meaning "take the accumulator"
  localparam logic [31:0] VALUE_FROM_ACCU = 32'hffffffff;

  // Register byte addresses
  localparam logic [4:0] ADDR_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_INSTR  = 5'h04;
  localparam logic [4:0] ADDR_VALUE  = 5'h08;
  localparam logic [4:0] ADDR_ACCU   = 5'h0c;
  localparam logic [4:0] ADDR_EXEC   = 5'h10;
  localparam logic [4:0] ADDR_PC     = 5'h14;
  localparam logic [4:0] ADDR_STATUS = 5'h18;

  // Field positions
  localparam int unsigned CTRL_RUN_BIT     = 0;
  localparam int unsigned CTRL_RESTART_BIT = 1;
  localparam int unsigned STAT_WAIT_BIT    = 0;
  localparam int unsigned STAT_FLAG_BIT    = 1;
  localparam int unsigned STAT_RUN_BIT     = 2;
  localparam int unsigned STAT_DEPTH_LSB   = 8;

  // Reset values
  localparam logic [31:0] WORD_RESET = 32'h00000000;

  typedef struct packed {
    logic [7:0] motor;
    logic [7:0] itype;
    logic [7:0] opcode;
  } instr_s;

endpackage : program_flow_pkg

// [hdl/program_flow_sequencer.sv]
// Purpose: Branch, call/return and wait part of a standalone script interpreter
// Assumes: Instructions arrive through INSTR/VALUE and are launched by a write to EXEC
// Notes:   EXEC writes stall on waitrequest while a wait instruction is pending

`timescale 1ns/10ps

module program_flow_sequencer #(
  parameter int unsigned NUM_MOTORS  = 1,
  parameter int unsigned PC_W        = 16,
  parameter int unsigned STACK_DEPTH = program_flow_pkg::STACK_DEPTH,
  parameter int unsigned TICK_CYCLES = program_flow_pkg::TICK_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [4:0]            address_i,
  input  wire logic                  read_i,
  input  wire logic                  write_i,
  input  wire logic [3:0]            byteenable_i,
  input  wire logic [31:0]           writedata_i,
  output logic      [31:0]           readdata_o,
  output logic                       waitrequest_o,
  input  wire logic [NUM_MOTORS-1:0] target_reached_i,
  input  wire logic [NUM_MOTORS-1:0] home_switch_i,
  input  wire logic [NUM_MOTORS-1:0] end_left_i,
  input  wire logic [NUM_MOTORS-1:0] end_right_i,
  input  wire logic [NUM_MOTORS-1:0] homing_done_i,
  output logic      [PC_W-1:0]       pc_o,
  output logic                       waiting_o,
  output logic                       timeout_error_o
);

  localparam int unsigned NS   = 5 * NUM_MOTORS;
  localparam int unsigned DW   = $clog2(STACK_DEPTH + 1);
  localparam int unsigned SW   = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
  localparam int unsigned PW   = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] PRESC_TOP = PW'(TICK_CYCLES - 1);
  localparam logic [DW-1:0] DEPTH_MAX = DW'(STACK_DEPTH);

  typedef enum logic {S_IDLE, S_WAIT} state_e;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic wait_met(input logic [7:0]    wtype,
                                    input logic [7:0]    motor,
                                    input logic [NS-1:0] st);
    logic r;
    int   m;
    r = 1'b0;
    m = int'(motor);
    if (m < NUM_MOTORS) begin
      case (wtype)
        program_flow_pkg::WAIT_TARGET: r = st[m];
        program_flow_pkg::WAIT_HOME:   r = st[NUM_MOTORS + m];
        program_flow_pkg::WAIT_END:    r = st[2*NUM_MOTORS + m] | st[3*NUM_MOTORS + m];
        program_flow_pkg::WAIT_HOMING: r = st[4*NUM_MOTORS + m];
        default:                       r = 1'b0;
      endcase
    end
    return r;
  endfunction : wait_met

  logic                     wait_q;
  logic [31:0]              readdata_q;
  logic                     run_q;
  program_flow_pkg::instr_s instr_q;
  logic [31:0]              value_q;
  logic [31:0]              accu_q;
  logic [PC_W-1:0]          pc_q;
  logic [DW-1:0]            depth_q;
  logic [PC_W-1:0]          stack_q [STACK_DEPTH];
  logic                     flag_q;
  state_e                   state_q;
  logic                     waiting_q;
  logic [7:0]               wtype_q;
  logic [7:0]               wmotor_q;
  logic [31:0]              cnt_q;
  logic [PW-1:0]            presc_q;
  logic                     tick_q;
  logic [NS-1:0]            sync1_q;
  logic [NS-1:0]            sync2_q;
  logic [NS-1:0]            sync3_q;
  logic [NS-1:0]            stat_q;
  logic [PC_W-1:0]          pushed_q;
  logic [DW-1:0]            pushed_depth_q;

  // Bus decode
  wire req_w      = read_i | write_i;
  wire hit_ctrl   = address_i == program_flow_pkg::ADDR_CTRL;
  wire hit_instr  = address_i == program_flow_pkg::ADDR_INSTR;
  wire hit_value  = address_i == program_flow_pkg::ADDR_VALUE;
  wire hit_accu   = address_i == program_flow_pkg::ADDR_ACCU;
  wire hit_exec   = address_i == program_flow_pkg::ADDR_EXEC;
  wire hit_pc     = address_i == program_flow_pkg::ADDR_PC;
  wire hit_status = address_i == program_flow_pkg::ADDR_STATUS;
  wire blocked_w  = write_i & hit_exec & waiting_q;
  wire wr_w       = write_i & ~wait_q;
  wire restart_w  = wr_w & hit_ctrl & byteenable_i[0]
                    & writedata_i[program_flow_pkg::CTRL_RESTART_BIT];
  wire exec_go_w  = wr_w & hit_exec;
  wire exec_run_w = exec_go_w & run_q;

  wire [31:0] ctrl_rd_w   = 32'(run_q) << program_flow_pkg::CTRL_RUN_BIT;
  wire [31:0] status_rd_w = (32'(depth_q) << program_flow_pkg::STAT_DEPTH_LSB)
                          | (32'(run_q) << program_flow_pkg::STAT_RUN_BIT)
                          | (32'(flag_q) << program_flow_pkg::STAT_FLAG_BIT)
                          | (32'(waiting_q) << program_flow_pkg::STAT_WAIT_BIT);
  wire [31:0] rd_mux_w = hit_ctrl   ? ctrl_rd_w :
                         hit_instr  ? 32'(instr_q) :
                         hit_value  ? value_q :
                         hit_accu   ? accu_q :
                         hit_pc     ? 32'(pc_q) :
                         hit_status ? status_rd_w : 32'h00000000;

  // Instruction decode
  wire [7:0] opc_w   = instr_q.opcode;
  wire [7:0] itype_w = instr_q.itype;
  wire is_branch_w = exec_run_w & (opc_w == program_flow_pkg::OPC_BRANCH);
  wire is_call_w   = exec_run_w & (opc_w == program_flow_pkg::OPC_CALL);
  wire is_ret_w    = exec_run_w & (opc_w == program_flow_pkg::OPC_RETURN);
  wire is_wait_w   = exec_run_w & (opc_w == program_flow_pkg::OPC_WAIT);
  wire is_clear_w  = exec_run_w & (opc_w == program_flow_pkg::OPC_CLEAR_ERROR);
  wire call_ok_w   = is_call_w & (depth_q < DEPTH_MAX);
  wire ret_ok_w    = is_ret_w & (depth_q != '0);
  wire cjmp_w      = exec_run_w & (opc_w == program_flow_pkg::OPC_COND_BRANCH)
                     & (itype_w == program_flow_pkg::COND_TIMEOUT) & flag_q;
  wire [31:0] cnt_src_w = (value_q == program_flow_pkg::VALUE_FROM_ACCU) ? accu_q
                                                                         : value_q;
  wire wtype_ok_w  = itype_w <= program_flow_pkg::WAIT_HOMING;
  wire wait_start_w = is_wait_w & wtype_ok_w
                      & ~((itype_w == program_flow_pkg::WAIT_TICKS) & (cnt_src_w == '0));
  wire [PC_W-1:0] top_w = stack_q[SW'(depth_q - DW'(1))];
  wire [PC_W-1:0] pc_inc_w = pc_q + PC_W'(1);

  // Wait tracking
  wire in_wait_w   = state_q == S_WAIT;
  wire ticks_w     = wtype_q == program_flow_pkg::WAIT_TICKS;
  wire cond_w      = in_wait_w & ~ticks_w & wait_met(wtype_q, wmotor_q, stat_q);
  wire expire_w    = in_wait_w & tick_q & (cnt_q == 32'h00000001);
  wire timeout_w   = expire_w & ~ticks_w & ~cond_w;
  wire wait_end_w  = cond_w | expire_w;

  wire [PC_W-1:0] pc_d = restart_w                       ? '0 :
                         wait_end_w                      ? pc_inc_w :
                         ~exec_run_w                     ? pc_q :
                         (is_branch_w | call_ok_w | cjmp_w) ? value_q[PC_W-1:0] :
                         ret_ok_w                        ? top_w + PC_W'(1) :
                         wait_start_w                    ? pc_q : pc_inc_w;
  wire [DW-1:0] depth_d = restart_w ? '0 :
                          call_ok_w ? depth_q + DW'(1) :
                          ret_ok_w  ? depth_q - DW'(1) : depth_q;
  wire flag_d = timeout_w ? 1'b1 : is_clear_w ? 1'b0 : flag_q;
  wire [31:0] cnt_d = wait_start_w             ? cnt_src_w :
                      (tick_q & (cnt_q != '0)) ? cnt_q - 32'h00000001 : cnt_q;
  wire [NS-1:0] raw_w = {homing_done_i, end_right_i, end_left_i, home_switch_i,
                         target_reached_i};

  // Bus slave: one wait cycle, EXEC held off while a wait runs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q     <= 1'b1;
      readdata_q <= program_flow_pkg::WORD_RESET;
    end else begin
      wait_q <= ~(req_w & wait_q & ~blocked_w);
      if (read_i & wait_q) begin
        readdata_q <= rd_mux_w;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q   <= 1'b0;
      instr_q <= '0;
      value_q <= program_flow_pkg::WORD_RESET;
      accu_q  <= program_flow_pkg::WORD_RESET;
    end else begin
      if (wr_w & hit_ctrl & byteenable_i[0]) begin
        run_q <= writedata_i[program_flow_pkg::CTRL_RUN_BIT];
      end
      if (wr_w & hit_instr) begin
        instr_q <= program_flow_pkg::instr_s'(24'(be_merge(32'(instr_q), writedata_i,
                                                          byteenable_i)));
      end
      if (wr_w & hit_value) begin
        value_q <= be_merge(value_q, writedata_i, byteenable_i);
      end
      if (wr_w & hit_accu) begin
        accu_q <= be_merge(accu_q, writedata_i, byteenable_i);
      end
    end
  end

  // Program counter, stack depth and error flag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_q    <= '0;
      depth_q <= '0;
      flag_q  <= 1'b0;
    end else begin
      pc_q    <= pc_d;
      depth_q <= depth_d;
      flag_q  <= flag_d;
    end
  end

  // Return stack storage
  always_ff @(posedge clk_i) begin
    if (call_ok_w) begin
      stack_q[SW'(depth_q)] <= pc_q;
      pushed_q              <= pc_q;
      pushed_depth_q        <= depth_q + DW'(1);
    end
  end

  // Wait state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q   <= S_IDLE;
      waiting_q <= 1'b0;
      wtype_q   <= program_flow_pkg::WAIT_TICKS;
      wmotor_q  <= 8'h00;
      cnt_q     <= '0;
    end else begin
      cnt_q <= cnt_d;
      case (state_q)
        S_IDLE: begin
          if (wait_start_w) begin
            state_q   <= S_WAIT;
            waiting_q <= 1'b1;
            wtype_q   <= itype_w;
            wmotor_q  <= instr_q.motor;
          end
        end
        S_WAIT: begin
          if (restart_w | wait_end_w) begin
            state_q   <= S_IDLE;
            waiting_q <= 1'b0;
          end
        end
        default: begin
          state_q   <= S_IDLE;
          waiting_q <= 1'b0;
        end
      endcase
    end
  end

  // Free-running tick prescaler
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc_q <= PRESC_TOP;
      tick_q  <= 1'b0;
    end else begin
      presc_q <= (presc_q == '0) ? PRESC_TOP : presc_q - PW'(1);
      tick_q  <= presc_q == '0;
    end
  end

  // Motion status: three stages, change taken when stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      stat_q  <= '0;
    end else begin
      sync1_q <= raw_w;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      stat_q  <= (sync2_q & sync3_q) | (stat_q & (sync2_q | sync3_q));
    end
  end

  assign readdata_o      = readdata_q;
  assign waitrequest_o   = wait_q;
  assign pc_o            = pc_q;
  assign waiting_o       = waiting_q;
  assign timeout_error_o = flag_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_BRANCH: assert property (is_branch_w & ~restart_w |=> pc_q == $past(value_q[PC_W-1:0]))
    else $error("branch did not load value");
  AST_CALL_PUSH: assert property (call_ok_w |=> depth_q == $past(depth_q) + DW'(1)
                                  && pc_q == $past(value_q[PC_W-1:0]))
    else $error("call did not push and jump");
  AST_DEPTH_MAX: assert property (depth_q <= DEPTH_MAX)
    else $error("stack depth above limit");
  AST_CALL_FULL: assert property (is_call_w && depth_q == DEPTH_MAX
                                  |=> depth_q == DEPTH_MAX && pc_q == $past(pc_inc_w))
    else $error("call on full stack not ignored");
  AST_CALL_RETURN: assert property (ret_ok_w && !restart_w && depth_q == pushed_depth_q
                                    |=> pc_q == $past(pushed_q) + PC_W'(1))
    else $error("return not after call");
  AST_RETURN_EMPTY: assert property (is_ret_w && depth_q == '0 && !restart_w
                                     |=> depth_q == '0 && pc_q == $past(pc_inc_w))
    else $error("return on empty stack not ignored");
  AST_WAIT_HOLD: assert property (waiting_q && !wait_end_w && !restart_w |=> $stable(pc_q))
    else $error("counter moved during wait");
  AST_TICKS_DONE: assert property (waiting_q && ticks_w && tick_q && cnt_q == 32'h1
                                   |=> !waiting_q && !$changed(flag_q))
    else $error("tick wait end wrong");
  AST_COND_RELEASE: assert property (cond_w && !restart_w
                                     |=> !waiting_q && pc_q == $past(pc_inc_w)
                                     && flag_q == $past(flag_q))
    else $error("condition did not release wait");
  AST_NO_TIMEOUT: assert property (waiting_q && !ticks_w && cnt_q == '0 |-> !timeout_w)
    else $error("timeout with zero value");
  AST_ACCU_SRC: assert property (wait_start_w && value_q == program_flow_pkg::VALUE_FROM_ACCU
                                 |=> cnt_q == $past(accu_q))
    else $error("accumulator not used as count");
  AST_TIMEOUT_SET: assert property (timeout_w && !restart_w
                                    |=> flag_q && !waiting_q && pc_q == $past(pc_inc_w))
    else $error("timeout did not set flag and release");
  AST_FLAG_HOLD: assert property (flag_q && !is_clear_w |=> flag_q)
    else $error("flag dropped without clear");
  AST_TICK_SPACING: assert property (tick_q |-> presc_q == PRESC_TOP ##1 !tick_q)
    else $error("tick spacing wrong");
  AST_HALTED: assert property (exec_go_w && !run_q && !restart_w
                               |=> $stable(pc_q) && $stable(depth_q) && !waiting_q)
    else $error("instruction acted while halted");
  AST_CJMP_FLAG: assert property (cjmp_w && !restart_w |=> pc_q == $past(value_q[PC_W-1:0]))
    else $error("timeout branch not taken");
  AST_TICK_COUNT: assert property (waiting_q && tick_q && cnt_q > 32'h1
                                   |=> cnt_q == $past(cnt_q) - 32'h1)
    else $error("wait count not stepped by tick");
  AST_RESTART: assert property (restart_w |=> depth_q == '0 && pc_q == '0 && !waiting_q)
    else $error("restart did not clear stack");

  COV_CALL: cover property (call_ok_w);
  COV_RETURN: cover property (ret_ok_w);
  COV_TIMEOUT: cover property (timeout_w);
  COV_COND: cover property (cond_w);

endmodule : program_flow_sequencer

// [tb/motion_status_model.sv]
// Purpose: Far-side model of the motion status lines seen by the sequencer
// Assumes: One motor; the bench picks which line to raise and when
// Notes:   Lines are registered levels, all low unless raised
`timescale 1ns/10ps

module motion_status_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] event_sel_i,
  input  wire logic       event_en_i,
  output logic            target_reached_o,
  output logic            home_switch_o,
  output logic            end_left_o,
  output logic            end_right_o,
  output logic            homing_done_o
);
  // Select 3 raises only the right switch, 5 only the left one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {target_reached_o, home_switch_o, end_left_o, end_right_o, homing_done_o} <= 5'h00;
    end else begin
      target_reached_o <= event_en_i && (event_sel_i == 3'h1);
      home_switch_o    <= event_en_i && (event_sel_i == 3'h2);
      end_right_o      <= event_en_i && (event_sel_i == 3'h3);
      homing_done_o    <= event_en_i && (event_sel_i == 3'h4);
      end_left_o       <= event_en_i && (event_sel_i == 3'h5);
    end
  end
endmodule : motion_status_model

// [tb/program_flow_sequencer_tb.sv]
// Purpose: Self-checking bench for the program flow sequencer
// Assumes: Tick shortened to 20 clocks; one motor
// Notes:   Program steps are issued over the register bus
`timescale 1ns/10ps

module program_flow_sequencer_tb;
  localparam int unsigned TC = 20;
  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  ty;
    logic [31:0] val;
    logic [31:0] pc;
    logic [3:0]  depth;
  } row_s;
  logic        clk_i        = 1'b0;
  logic        rst_n_i      = 1'b0;
  logic [4:0]  address_i    = 5'h00;
  logic        read_i       = 1'b0;
  logic        write_i      = 1'b0;
  logic [3:0]  byteenable_i = 4'hf;
  logic [31:0] writedata_i  = 32'h0;
  logic [31:0] readdata_o;
  logic [31:0] rd;
  logic        waitrequest_o;
  logic        waiting_o;
  logic        timeout_error_o;
  logic [15:0] pc_o;
  logic [2:0]  event_sel    = 3'h0;
  logic        event_en     = 1'b0;
  logic        tgt, hsw, el, er, hdn;
  int          n_errors     = 0;
  int          comparisons  = 0;
  int          cyc          = 0;
  int          t0;
  int          elapsed;
  row_s        rows [8] = '{
    '{program_flow_pkg::OPC_BRANCH, 8'h05, 32'h40, 32'h40, 4'h0},
    '{program_flow_pkg::OPC_CALL, 8'h00, 32'h100, 32'h100, 4'h1},
    '{program_flow_pkg::OPC_CALL, 8'h00, 32'h200, 32'h200, 4'h2},
    '{program_flow_pkg::OPC_RETURN, 8'h00, 32'h0, 32'h101, 4'h1},
    '{program_flow_pkg::OPC_RETURN, 8'h00, 32'h0, 32'h41, 4'h0},
    '{program_flow_pkg::OPC_RETURN, 8'h00, 32'h0, 32'h42, 4'h0},
    '{program_flow_pkg::OPC_COND_BRANCH, 8'h08, 32'h10, 32'h43, 4'h0},
    '{program_flow_pkg::OPC_WAIT, 8'h00, 32'h0, 32'h44, 4'h0}};

  program_flow_sequencer #(.TICK_CYCLES(TC)) program_flow_sequencer_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .byteenable_i(byteenable_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .target_reached_i(tgt),
    .home_switch_i(hsw), .end_left_i(el), .end_right_i(er), .homing_done_i(hdn),
    .pc_o(pc_o), .waiting_o(waiting_o), .timeout_error_o(timeout_error_o));

  motion_status_model motion_status_model_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .event_sel_i(event_sel), .event_en_i(event_en),
    .target_reached_o(tgt), .home_switch_o(hsw), .end_left_o(el), .end_right_o(er),
    .homing_done_o(hdn));

  always #10 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until waitrequest is sampled low
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    address_i   <= a;
    writedata_i <= d;
    write_i     <= 1'b1;
    do @(posedge clk_i); while (waitrequest_o !== 1'b0);
    write_i <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_i);
    address_i <= a;
    read_i    <= 1'b1;
    do @(posedge clk_i); while (waitrequest_o !== 1'b0);
    d = readdata_o;
    read_i <= 1'b0;
  endtask : bus_rd

  task automatic exec(input logic [7:0] op, input logic [7:0] ty, input logic [31:0] v);
    bus_wr(program_flow_pkg::ADDR_INSTR, {16'h0, ty, op});
    bus_wr(program_flow_pkg::ADDR_VALUE, v);
    t0 = cyc;
    bus_wr(program_flow_pkg::ADDR_EXEC, 32'h0);
    do @(posedge clk_i); while (waiting_o === 1'b1);
    elapsed = cyc - t0;
  endtask : exec

  task automatic expect_state(input logic [31:0] pc, input logic [3:0] depth, input logic flag);
    bus_rd(program_flow_pkg::ADDR_PC, rd);
    chk(rd, pc);
    bus_rd(program_flow_pkg::ADDR_STATUS, rd);
    chk({27'h0, rd[11:8], rd[1]}, {27'h0, depth, flag});
  endtask : expect_state

  initial begin
    repeat (3) @(posedge clk_i);
    chk({15'h0, waitrequest_o, pc_o}, 32'h10000);
    chk({30'h0, waiting_o, timeout_error_o}, 32'h0);
    rst_n_i <= 1'b1;
    bus_wr(program_flow_pkg::ADDR_CTRL, 32'h3);
    foreach (rows[i]) begin
      exec(rows[i].op, rows[i].ty, rows[i].val);
      expect_state(rows[i].pc, rows[i].depth, 1'b0);
    end
    for (int i = 1; i <= 9; i++) exec(program_flow_pkg::OPC_CALL, 8'h00, 32'(i * 16));
    expect_state(32'h81, 4'h8, 1'b0);
    exec(program_flow_pkg::OPC_RETURN, 8'h00, 32'h0);
    expect_state(32'h71, 4'h7, 1'b0);
    bus_wr(program_flow_pkg::ADDR_CTRL, 32'h3);
    expect_state(32'h0, 4'h0, 1'b0);
    exec(program_flow_pkg::OPC_WAIT, program_flow_pkg::WAIT_TICKS, 32'h3);
    chk(32'(elapsed >= 2 * TC && elapsed <= 3 * TC + 4), 32'h1);
    bus_wr(program_flow_pkg::ADDR_ACCU, 32'h2);
    exec(program_flow_pkg::OPC_WAIT, program_flow_pkg::WAIT_TICKS, program_flow_pkg::VALUE_FROM_ACCU);
    chk(32'(elapsed >= TC && elapsed <= 2 * TC + 4), 32'h1);
    exec(program_flow_pkg::OPC_WAIT, program_flow_pkg::WAIT_TARGET, 32'h2);
    chk(32'(elapsed >= TC && elapsed <= 2 * TC + 4), 32'h1);
    expect_state(32'h3, 4'h0, 1'b1);
    exec(program_flow_pkg::OPC_COND_BRANCH, program_flow_pkg::COND_TIMEOUT, 32'h55);
    expect_state(32'h55, 4'h0, 1'b1);
    exec(program_flow_pkg::OPC_CLEAR_ERROR, 8'h00, 32'h0);
    expect_state(32'h56, 4'h0, 1'b0);
    for (int t = 1; t <= 5; t++) begin
      event_sel <= 3'(t);
      fork
        exec(program_flow_pkg::OPC_WAIT, (t == 5) ? program_flow_pkg::WAIT_END : 8'(t), 32'h0);
        begin
          do @(posedge clk_i); while (waiting_o !== 1'b1);
          repeat (3 * TC) @(posedge clk_i);
          event_en <= 1'b1;
        end
      join
      event_en <= 1'b0;
      chk(32'(elapsed >= 3 * TC && elapsed <= 3 * TC + 12), 32'h1);
      expect_state(32'(32'h56 + t), 4'h0, 1'b0);
      repeat (6) @(posedge clk_i);
    end
    bus_wr(program_flow_pkg::ADDR_CTRL, 32'h0);
    exec(program_flow_pkg::OPC_BRANCH, 8'h00, 32'h77);
    expect_state(32'h5b, 4'h0, 1'b0);
    bus_rd(5'h1c, rd);
    chk(rd, 32'h0);
    bus_wr(program_flow_pkg::ADDR_ACCU, 32'h11223344);
    byteenable_i <= 4'h2;
    bus_wr(program_flow_pkg::ADDR_ACCU, 32'haabbccdd);
    byteenable_i <= 4'hf;
    bus_rd(program_flow_pkg::ADDR_ACCU, rd);
    chk(rd, 32'h1122cc44);
    // Reset in mid-run while a call is stacked and a wait is pending
    bus_wr(program_flow_pkg::ADDR_CTRL, 32'h1);
    exec(program_flow_pkg::OPC_CALL, 8'h00, 32'h30);
    bus_wr(program_flow_pkg::ADDR_INSTR,
           {16'h0, program_flow_pkg::WAIT_HOME, program_flow_pkg::OPC_WAIT});
    bus_wr(program_flow_pkg::ADDR_VALUE, 32'h0);
    bus_wr(program_flow_pkg::ADDR_EXEC, 32'h0);
    repeat (4) @(posedge clk_i);
    chk({15'h0, waiting_o, pc_o}, 32'h10030);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk({15'h0, waitrequest_o, pc_o}, 32'h10000);
    chk({30'h0, waiting_o, timeout_error_o}, 32'h0);
    chk(readdata_o, 32'h0);
    expect_state(32'h0, 4'h0, 1'b0);
    tally_and_finish();
  end
endmodule : program_flow_sequencer_tb
